// ==== hdl/tcd_dma.sv ====
// two-channel dma controller with axi4-lite register slave
// Overview of operation
// - a 16-bit count per channel sets how many transfers run, up to 64K
// - registers stay writable while running and act at once, even mid-transfer
// - control words reset to fff9; source, destination and count registers reset to zero
// - control bit 15 puts destination in memory (1) or I/O (0)
// - bit 14 alone steps destination down, bit 13 alone up, by 1 or 2
// - control bit 12 puts source in memory (1) or I/O (0)
// - bit 11 alone steps source down, bit 10 alone up, by 1 or 2
// - count drops by one on every transfer in every mode
// - bit 9 set stops synchronised activity at count zero, clear runs past it
// - unsynchronised activity always stops at count zero
// - bit 8 with bit 9 raises an interrupt request on count completion
// - bits 7-6 pick none, source or destination handshake; 11 is reserved
// - bit 5 set on one channel alone makes it win a simultaneous request, otherwise channel 0 wins
// - bit 4 lets timer 2 requests reach the channel, clear blocks them
// - a control write changes the run bit only when bit 2 is written 1
// - run bit 1 starts the channel, clearing it stops; bit 3 reserved
// - bit 0 picks word (1) or byte (0) transfers
// - destination handshake releases the bus and waits two clocks between transfers
// - other modes may start the next transfer right after the last one
// - high address bits drive lines 19-16, destination on write, source on read
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module tcd_dma
  import tcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tcd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic channel0_request_pin,
  input wire logic channel1_request_pin,
  input wire logic timer2_request,
  output logic mem_req,
  output logic mem_write,
  output logic mem_space_memory,
  output logic mem_word,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic [1:0] dma_irq,
  output logic dma_busy
);
  logic [19:0] src_q [CHANNELS];
  logic [19:0] dst_q [CHANNELS];
  logic [15:0] cnt_q [CHANNELS];
  logic [15:0] ctl_q [CHANNELS];
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [4:0] wdec;
  logic [4:0] rdec;
  logic [15:0] ctl_wr;
  tcd_state_t state_q;
  logic act_q;
  logic [1:0] gap_q;
  logic [1:0] req_ch;
  logic grant_ch;
  logic xfer_done;
  logic [15:0] cnt_next;
  logic stop_at_zero [CHANNELS];
  // {hit, channel, selector}; only word-aligned addresses hit
  function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a[1:0] == 2'h0)
    begin
      unique case (a[ADDR_W-1:2])
        OFF_CH0_SRC_LO: r = {2'b10, SEL_SRC_LO};
        OFF_CH0_SRC_HI: r = {2'b10, SEL_SRC_HI};
        OFF_CH0_DST_LO: r = {2'b10, SEL_DST_LO};
        OFF_CH0_DST_HI: r = {2'b10, SEL_DST_HI};
        OFF_CH0_COUNT: r = {2'b10, SEL_COUNT};
        OFF_CH0_CTRL: r = {2'b10, SEL_CTRL};
        OFF_CH1_SRC_LO: r = {2'b11, SEL_SRC_LO};
        OFF_CH1_SRC_HI: r = {2'b11, SEL_SRC_HI};
        OFF_CH1_DST_LO: r = {2'b11, SEL_DST_LO};
        OFF_CH1_DST_HI: r = {2'b11, SEL_DST_HI};
        OFF_CH1_COUNT: r = {2'b11, SEL_COUNT};
        OFF_CH1_CTRL: r = {2'b11, SEL_CTRL};
        default: r = 5'h00;
      endcase
    end
    return r;
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
    return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction
  // step after a transfer: equal bits hold the address
  function automatic logic [19:0] step(input logic [19:0] a, input logic down, input logic up, input logic word);
    logic [19:0] s;
    s = word ? STEP_WORD : STEP_BYTE;
    if (down && !up)
      return a - s;
    else if (up && !down)
      return a + s;
    else
      return a;
  endfunction
  assign wdec = decode(awaddr_q);
  assign rdec = decode(s_axi_araddr);
  assign ctl_wr = merge(ctl_q[wdec[3]], wdata_q[15:0], wstrb_q[1:0]);
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  // axi4-lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wdec[4] ? RESP_OKAY : RESP_SLVERR;
      end
      // ready returns only once the response is taken: one write at a time
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // axi4-lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rdec[4] ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata <= 32'h0000_0000;
        if (rdec[4])
        begin
          unique case (rdec[2:0])
            SEL_SRC_LO: s_axi_rdata <= {16'h0000, src_q[rdec[3]][15:0]};
            SEL_SRC_HI: s_axi_rdata <= {28'h000_0000, src_q[rdec[3]][19:16]};
            SEL_DST_LO: s_axi_rdata <= {16'h0000, dst_q[rdec[3]][15:0]};
            SEL_DST_HI: s_axi_rdata <= {28'h000_0000, dst_q[rdec[3]][19:16]};
            SEL_COUNT: s_axi_rdata <= {16'h0000, cnt_q[rdec[3]]};
            default: s_axi_rdata <= {16'h0000, ctl_q[rdec[3]]};
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  // request qualification
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_req
      logic pin;
      logic [1:0] kind;
      assign pin = (g == 0) ? channel0_request_pin : channel1_request_pin;
      assign kind = ctl_q[g][B_SYNC_HI:B_SYNC_LO];
      // unsynchronised always stops at zero, synchronised only with stop bit
      assign stop_at_zero[g] = (kind == SYNC_NONE) || ctl_q[g][B_TC_STOP];
      assign req_ch[g] = ctl_q[g][B_RUN]
        && (kind != (SYNC_SRC | SYNC_DST))
        && !(stop_at_zero[g] && cnt_q[g] == COUNT_ZERO)
        && (kind == SYNC_NONE || pin || (timer2_request && ctl_q[g][B_TIMER_ALLOW]));
    end
  endgenerate
  // channel 1 wins only with its priority bit alone set
  assign grant_ch = req_ch[1] && (!req_ch[0] || (ctl_q[1][B_PRIO] && !ctl_q[0][B_PRIO]));
  assign xfer_done = (state_q == ST_DEPOSIT) && mem_ack;
  assign cnt_next = cnt_q[act_q] - COUNT_ONE;
  // channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        src_q[c] <= ADDR_RESET;
        dst_q[c] <= ADDR_RESET;
        cnt_q[c] <= COUNT_RESET;
        ctl_q[c] <= CTRL_RESET;
      end
    end
    else
    begin
      if (xfer_done)
      begin
        // live control bits are used, so a mid-transfer change applies now
        src_q[act_q] <= step(src_q[act_q], ctl_q[act_q][B_SRC_DOWN], ctl_q[act_q][B_SRC_UP],
                             ctl_q[act_q][B_WORD]);
        dst_q[act_q] <= step(dst_q[act_q], ctl_q[act_q][B_DEST_DOWN], ctl_q[act_q][B_DEST_UP],
                             ctl_q[act_q][B_WORD]);
        cnt_q[act_q] <= cnt_next;
        if (cnt_next == COUNT_ZERO && stop_at_zero[act_q])
          ctl_q[act_q][B_RUN] <= 1'b0;
      end
      // a software write lands after the transfer update and so wins
      if (do_write && wdec[4])
      begin
        unique case (wdec[2:0])
          SEL_SRC_LO: src_q[wdec[3]][15:0] <= merge(src_q[wdec[3]][15:0], wdata_q[15:0], wstrb_q[1:0]);
          SEL_SRC_HI: if (wstrb_q[0]) src_q[wdec[3]][19:16] <= wdata_q[3:0];
          SEL_DST_LO: dst_q[wdec[3]][15:0] <= merge(dst_q[wdec[3]][15:0], wdata_q[15:0], wstrb_q[1:0]);
          SEL_DST_HI: if (wstrb_q[0]) dst_q[wdec[3]][19:16] <= wdata_q[3:0];
          SEL_COUNT: cnt_q[wdec[3]] <= merge(cnt_q[wdec[3]], wdata_q[15:0], wstrb_q[1:0]);
          default:
          begin
            ctl_q[wdec[3]] <= {ctl_wr[15:2],
                               (wstrb_q[0] && wdata_q[B_UNLOCK]) ? wdata_q[B_RUN] : ctl_q[wdec[3]][B_RUN],
                               wstrb_q[0] ? wdata_q[B_WORD] : ctl_q[wdec[3]][B_WORD]};
          end
        endcase
      end
    end
  end
  // transfer sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      act_q <= 1'b0;
      gap_q <= 2'h0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_space_memory <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= ADDR_RESET;
      mem_wdata <= 16'h0000;
      dma_busy <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (|req_ch)
          begin
            act_q <= grant_ch;
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_addr <= src_q[grant_ch];
            mem_space_memory <= ctl_q[grant_ch][B_SRC_SPACE];
            mem_word <= ctl_q[grant_ch][B_WORD];
            dma_busy <= 1'b1;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (mem_ack)
          begin
            mem_write <= 1'b1;
            mem_wdata <= mem_rdata;
            mem_addr <= dst_q[act_q];
            mem_space_memory <= ctl_q[act_q][B_DEST_SPACE];
            mem_word <= ctl_q[act_q][B_WORD];
            state_q <= ST_DEPOSIT;
          end
        end
        ST_DEPOSIT:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            dma_busy <= 1'b0;
            // destination handshake gives the bus back and lets the pin fall
            if (ctl_q[act_q][B_SYNC_HI:B_SYNC_LO] == SYNC_DST)
            begin
              gap_q <= GAP_CLOCKS - 2'h1;
              state_q <= ST_GAP;
            end
            else
              state_q <= ST_IDLE;
          end
        end
        ST_GAP:
        begin
          gap_q <= gap_q - 2'h1;
          if (gap_q == 2'h0)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end
  // completion interrupt request pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_irq <= 2'b00;
    else
    begin
      dma_irq <= 2'b00;
      if (xfer_done && cnt_next == COUNT_ZERO && ctl_q[act_q][B_IRQ] && ctl_q[act_q][B_TC_STOP])
        dma_irq[act_q] <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ==== common/tcd_pkg.sv ====
// shared constants for the two-channel dma controller
package tcd_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [9:0] OFF_CH0_SRC_LO = 10'h00c0;
  localparam logic [9:0] OFF_CH0_SRC_HI = 10'h00c2;
  localparam logic [9:0] OFF_CH0_DST_LO = 10'h00c4;
  localparam logic [9:0] OFF_CH0_DST_HI = 10'h00c6;
  localparam logic [9:0] OFF_CH0_COUNT = 10'h00c8;
  localparam logic [9:0] OFF_CH0_CTRL = 10'h00ca;
  localparam logic [9:0] OFF_CH1_SRC_LO = 10'h00d0;
  localparam logic [9:0] OFF_CH1_SRC_HI = 10'h00d2;
  localparam logic [9:0] OFF_CH1_DST_LO = 10'h00d4;
  localparam logic [9:0] OFF_CH1_DST_HI = 10'h00d6;
  localparam logic [9:0] OFF_CH1_COUNT = 10'h00d8;
  localparam logic [9:0] OFF_CH1_CTRL = 10'h00da;

  localparam int ADDR_W = 12;
  localparam int CHANNELS = 2;

  // register selectors inside a channel
  localparam logic [2:0] SEL_SRC_LO = 3'h0;
  localparam logic [2:0] SEL_SRC_HI = 3'h1;
  localparam logic [2:0] SEL_DST_LO = 3'h2;
  localparam logic [2:0] SEL_DST_HI = 3'h3;
  localparam logic [2:0] SEL_COUNT = 3'h4;
  localparam logic [2:0] SEL_CTRL = 3'h5;

  localparam logic [15:0] CTRL_RESET = 16'hfff9;
  localparam logic [19:0] ADDR_RESET = 20'h0_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // control word bit positions
  localparam int B_DEST_SPACE = 15;
  localparam int B_DEST_DOWN = 14;
  localparam int B_DEST_UP = 13;
  localparam int B_SRC_SPACE = 12;
  localparam int B_SRC_DOWN = 11;
  localparam int B_SRC_UP = 10;
  localparam int B_TC_STOP = 9;
  localparam int B_IRQ = 8;
  localparam int B_SYNC_HI = 7;
  localparam int B_SYNC_LO = 6;
  localparam int B_PRIO = 5;
  localparam int B_TIMER_ALLOW = 4;
  localparam int B_UNLOCK = 2;
  localparam int B_RUN = 1;
  localparam int B_WORD = 0;

  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_SRC = 2'h1;
  localparam logic [1:0] SYNC_DST = 2'h2;

  localparam logic [19:0] STEP_BYTE = 20'h0_0001;
  localparam logic [19:0] STEP_WORD = 20'h0_0002;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // extra idle clocks between destination-synchronised transfers
  localparam logic [1:0] GAP_CLOCKS = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_DEPOSIT = 4'b0100,
    ST_GAP = 4'b1000
  } tcd_state_t;

endpackage

// ==== tb/tcd_dma_props.sv ====
// concurrent checks on the ports of the two-channel dma controller
`timescale 1ns/10ps
`default_nettype none
module tcd_dma_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic [1:0] dma_irq,
  input wire logic dma_busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("bus cycle changed before acknowledge");
  fetch_deposit_a: assert property (mem_req && !mem_write && mem_ack |=>
    mem_req && mem_write && mem_wdata == $past(mem_rdata)) else $error("fetch not followed by deposit");
  deposit_end_a: assert property (mem_req && mem_write && mem_ack |=> !mem_req && !dma_busy)
    else $error("transfer did not end after deposit");
  busy_req_a: assert property (mem_req |-> dma_busy)
    else $error("bus cycle outside a transfer");
  irq_cause_a: assert property (dma_irq != 2'b00 |-> $past(mem_req && mem_write && mem_ack))
    else $error("completion pulse without a finished transfer");
  irq_pulse_a: assert property (dma_irq != 2'b00 |=> dma_irq == 2'b00)
    else $error("completion pulse longer than one cycle");
  cover property (mem_req && mem_write && mem_ack);
  cover property (dma_irq[0]);
  cover property (dma_irq[1]);
endmodule

bind tcd_dma tcd_dma_props tcd_dma_props_i (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_write, .mem_addr, .mem_wdata,
  .mem_ack, .mem_rdata, .dma_irq, .dma_busy);
`default_nettype wire

// ==== tb/tcd_mem_model.sv ====
// memory and i/o partner answering fetch and deposit bus cycles
`timescale 1ns/10ps
`default_nettype none
module tcd_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic slow,
  input wire logic [19:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [2:0] wait_q;
  // all regions are 16 bits wide, so word cycles are always legal here
  always @(posedge aclk)
  begin
    mem_rdata <= ~mem_rdata;
    if (!aresetn || mem_ack || !mem_req)
    begin
      mem_ack <= 1'b0;
      wait_q <= 3'h0;
    end
    else if (wait_q >= (slow ? 3'h3 : 3'h0))
    begin
      mem_ack <= 1'b1;
      if (!mem_write) mem_rdata <= mem_addr[15:0] ^ 16'h5a3c;
    end
    else
      wait_q <= wait_q + 3'h1;
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the two-channel dma controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tcd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, dma_irq;
  // request pins are plain inputs here, no pin sharing to set up
  logic channel0_request_pin = 0, channel1_request_pin = 0, timer2_request = 0, slow = 0;
  logic mem_req, mem_write, mem_space_memory, mem_word, mem_ack, dma_busy;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  int bad_count = 0, compares = 0, ndep = 0, lowc = 0, gap = 0, stop_at = 0, irqs = 0;
  logic [31:0] lf = 32'h709d;
  logic [21:0] fq[$];
  logic [37:0] dq[$];

  tcd_dma tcd_dma_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel0_request_pin,
    .channel1_request_pin, .timer2_request, .mem_req, .mem_write, .mem_space_memory, .mem_word, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .dma_irq, .dma_busy);
  tcd_mem_model tcd_mem_model_i (.aclk, .aresetn, .mem_req, .mem_write, .slow, .mem_addr, .mem_ack, .mem_rdata);

  initial forever #50 aclk = ~aclk;

  function logic [19:0] rnd();
    lf = (lf >> 1) ^ (lf[0] ? 32'h8020_0003 : 32'h0000_0000);
    return lf[19:0];
  endfunction

  function automatic logic [9:0] ix(input int ch, input logic [2:0] sel);
    return OFF_CH0_SRC_LO + (ch ? 10'h010 : 10'h000) + {6'h0, sel, 1'b0};
  endfunction

  function automatic logic [15:0] cw(logic dsp, logic [1:0] dd, logic ssp, logic [1:0] sd, logic tc, logic irq,
    logic [1:0] sy, logic pr, logic tm, logic run, logic wd);
    return {dsp, dd, ssp, sd, tc, irq, sy, pr, tm, 1'b0, 1'b1, run, wd};
  endfunction

  function automatic logic [19:0] stp(logic [19:0] a, logic [1:0] dir, logic wd);
    logic [19:0] s = wd ? STEP_WORD : STEP_BYTE;
    return dir == 2'b10 ? a - s : dir == 2'b01 ? a + s : a;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("[FAIL] wait expected answer seen none");
    tally_and_finish();
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d, output logic [1:0] rsp);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang();
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] rsp);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang();
  endtask

  task automatic rchk(input string n, input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(n, d, e);
  endtask

  task automatic cfg(input int ch, input logic [19:0] s, input logic [19:0] d, input logic [15:0] c,
    input logic [15:0] w);
    logic [1:0] r;
    wr(ix(ch, SEL_SRC_LO), s[15:0], r);
    wr(ix(ch, SEL_SRC_HI), {12'h000, s[19:16]}, r);
    wr(ix(ch, SEL_DST_LO), d[15:0], r);
    wr(ix(ch, SEL_DST_HI), {12'h000, d[19:16]}, r);
    wr(ix(ch, SEL_COUNT), c, r);
    wr(ix(ch, SEL_CTRL), w, r);
    chk("write resp", r, RESP_OKAY);
  endtask

  // extra edges after the last deposit let a surplus transfer show up
  task automatic wait_dep(input int n);
    int k;
    for (k = 0; k < 400; k++)
    begin
      @(posedge aclk);
      #1;
      if (ndep >= n) break;
    end
    if (k == 400) hang();
    repeat (24) @(posedge aclk);
  endtask

  task automatic vfy(input int n, input logic [19:0] s, input logic [19:0] d, input logic [15:0] w);
    logic [21:0] f;
    logic [37:0] p;
    chk("deposits", ndep, n);
    repeat (n)
    begin
      f = fq.pop_front();
      p = dq.pop_front();
      chk("fetch addr", f[21:2], s);
      chk("fetch space", f[1], w[B_SRC_SPACE]);
      chk("word", {f[0], p[0]}, {2{w[B_WORD]}});
      chk("deposit addr", p[37:18], d);
      chk("deposit space", p[1], w[B_DEST_SPACE]);
      chk("deposit data", p[17:2], s[15:0] ^ 16'h5a3c);
      s = stp(s, w[B_SRC_DOWN:B_SRC_UP], w[B_WORD]);
      d = stp(d, w[B_DEST_DOWN:B_DEST_UP], w[B_WORD]);
    end
    ndep = 0;
    fq.delete();
    dq.delete();
  endtask

  always @(posedge aclk)
  begin
    if (mem_req && mem_ack && mem_write)
    begin
      dq.push_back({mem_addr, mem_wdata, mem_space_memory, mem_word});
      ndep++;
      if (ndep == stop_at) channel0_request_pin <= 1'b0;
    end
    else if (mem_req && mem_ack) fq.push_back({mem_addr, mem_space_memory, mem_word});
    if (mem_req && lowc != 0) gap = lowc;
    lowc = mem_req ? 0 : lowc + 1;
    irqs += $countones(dma_irq);
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [19:0] s, t;
    logic [15:0] w;
    int i;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl0 reset", OFF_CH0_CTRL, 32'h0000_fff9);
    rchk("ctrl1 reset", OFF_CH1_CTRL, 32'h0000_fff9);
    rd(10'h0e0, d, r);
    chk("unmapped resp", {d, r}, {32'h0000_0000, RESP_SLVERR});
    wr(OFF_CH0_CTRL, 16'h0002, r);
    rchk("run locked", OFF_CH0_CTRL, 32'h0000_0000);
    for (i = 0; i < 4; i++)
    begin
      s = rnd();
      t = rnd();
      slow <= s[7];
      irqs = 0;
      w = cw(s[0], i[1:0], t[0], ~i[1:0], t[5], 1'b1, SYNC_NONE, 1'b0, 1'b0, 1'b1, i[0]);
      cfg(i % 2, s, t, 16'h0003, w);
      wait_dep(3);
      vfy(3, s, t, w);
      chk("unsync gap", gap, 1);
      chk("irq count", irqs, w[B_TC_STOP]);
      rchk("count end", ix(i % 2, SEL_COUNT), 32'h0000_0000);
      rchk("run cleared", ix(i % 2, SEL_CTRL), {16'h0000, w & 16'hfffd});
    end
    s = rnd();
    t = rnd();
    irqs = 0;
    stop_at = 2;
    w = cw(1'b1, 2'b01, 1'b1, 2'b01, 1'b0, 1'b1, SYNC_SRC, 1'b0, 1'b0, 1'b1, 1'b1);
    cfg(0, s, t, 16'h0001, w);
    channel0_request_pin <= 1'b1;
    wait_dep(2);
    vfy(2, s, t, w);
    rchk("count wrapped", ix(0, SEL_COUNT), 32'h0000_ffff);
    chk("irq without stop", irqs, 0);
    wr(OFF_CH0_CTRL, w & 16'hfffd, r);
    rchk("stopped", OFF_CH0_CTRL, {16'h0000, w & 16'hfffd});
    stop_at = 0;
    irqs = 0;
    w = cw(1'b0, 2'b10, 1'b1, 2'b00, 1'b1, 1'b1, SYNC_DST, 1'b0, 1'b1, 1'b1, 1'b0);
    cfg(1, s, t, 16'h0002, w);
    timer2_request <= 1'b1;
    wait_dep(2);
    vfy(2, s, t, w);
    chk("dest gap", gap, 1 + GAP_CLOCKS);
    chk("irq dest", irqs, 1);
    rchk("dest stop", ix(1, SEL_CTRL), {16'h0000, w & 16'hfffd});
    cfg(0, s, t, 16'h0002, cw(1'b0, 2'b00, 1'b0, 2'b00, 1'b1, 1'b0, SYNC_DST, 1'b0, 1'b0, 1'b1, 1'b0));
    cfg(1, s, t, 16'h0002, cw(1'b0, 2'b00, 1'b0, 2'b00, 1'b1, 1'b0, 2'b11, 1'b0, 1'b1, 1'b1, 1'b0));
    repeat (30) @(posedge aclk);
    chk("blocked", ndep, 0);
    timer2_request <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      s = rnd();
      t = rnd();
      cfg(0, s, t, 16'h0001, cw(1'b1, 2'b00, 1'b1, 2'b00, 1'b1, 1'b0, SYNC_SRC, 1'b0, 1'b0, 1'b1, 1'b0));
      cfg(1, t, s, 16'h0001, cw(1'b1, 2'b00, 1'b1, 2'b00, 1'b1, 1'b0, SYNC_SRC, i[0], 1'b0, 1'b1, 1'b0));
      channel0_request_pin <= 1'b1;
      channel1_request_pin <= 1'b1;
      wait_dep(2);
      chk("first fetch", fq[0][21:2], i ? t : s);
      ndep = 0;
      fq.delete();
      dq.delete();
      channel0_request_pin <= 1'b0;
      channel1_request_pin <= 1'b0;
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
